// [hdl/pdbmc_phy.sv]
`timescale 1ns/1ps

module pdbmc_fifo #(
   parameter int W = 2,
   parameter int D = 8
) (
   input  wire logic         clk_sys,   // Core clock.
   input  wire logic         rst_n,     // Synchronous reset, active low.
   input  wire logic [W-1:0] in_data,   // Word to store.
   input  wire logic         in_valid,  // Word offered.
   output logic              in_ready,  // Room for a word.
   output logic [W-1:0]      out_data,  // Oldest word.
   output logic              out_valid, // Oldest word present.
   input  wire logic         out_ready  // Oldest word taken.
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(D);
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);
   localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);
   localparam logic [AW-1:0] PTR_ONE  = AW'(1);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic          rdy;
   } pdbmc_fifo_s;

   pdbmc_fifo_s   st_q;
   pdbmc_fifo_s   st_d;
   logic [W-1:0]  mem [D];
   logic          push;
   logic          pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
   endfunction

   assign push      = in_valid && st_q.rdy;
   assign pop       = out_ready && (st_q.cnt != '0);
   assign in_ready  = st_q.rdy;
   assign out_valid = (st_q.cnt != '0);
   assign out_data  = mem[st_q.rp];

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wp = ptr_inc(st_q.wp);
      end
      if (pop) begin
         st_d.rp = ptr_inc(st_q.rp);
      end
      if (push && !pop) begin
         st_d.cnt = st_q.cnt + CNT_ONE;
      end else if (pop && !push) begin
         st_d.cnt = st_q.cnt - CNT_ONE;
      end
      st_d.rdy = (st_d.cnt != CNT_FULL);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
      end else begin
         st_q <= st_d;
      end
      if (push) begin
         mem[st_q.wp] <= in_data;
      end
   end

endmodule

// Functional notes
// - Every bit starts with a line edge and a one adds a second edge mid-bit.
// - The line stays nearly DC balanced, off by no more than half a bit.
// - A message opens by driving the line low before the first edge.
// - When the first edge is missed the receiver loses the first bit.
// - One extra edge follows the final bit so the far end can clock it in.
// - The driver is enabled only while sending and released otherwise.
// - One channel pin is used per connection, with no switching during it.
// - Each port has its own pin pair and traffic uses exactly one of them.
// - Only one party drives the shared wire and all others stay released.
// - A squelch detector reports bus idle and sending starts only then.
// - Coded data goes out on the same pin that carries the attach bias.
module pdbmc_phy
   import pdbmc_pkg::*;
(
   input  wire logic clk_sys,        // Core clock, 25 MHz.
   input  wire logic rst_n,          // Synchronous reset, active low.
   input  wire logic connect,        // Attach detected, same clock.
   input  wire logic orient_b,       // Plug mates with pin b, same clock.
   input  wire logic tx_valid,       // Symbol bit offered.
   input  wire logic tx_data,        // Symbol bit value.
   input  wire logic tx_last,        // Final bit of the packet.
   output logic      tx_ready,       // Buffer accepts a bit.
   output logic      rx_valid,       // Decoded bit strobe.
   output logic      rx_data,        // Decoded bit value.
   output logic      rx_idle,        // Squelch reports bus idle.
   output logic      tx_busy,        // Driving the wire.
   input  wire logic pin_a_in,       // Channel pin a level.
   output logic      pin_a_out,      // Channel pin a drive level.
   output logic      pin_a_oe_n,     // Channel pin a enable, low drives.
   input  wire logic pin_b_in,       // Channel pin b level.
   output logic      pin_b_out,      // Channel pin b drive level.
   output logic      pin_b_oe_n      // Channel pin b enable, low drives.
);

   typedef struct packed {
      pdbmc_tx_e  tx_st;
      pdbmc_cnt_t tx_cnt;
      logic       tx_half;
      pdbmc_sym_s tx_sym;
      logic       line;
      logic       drive;
      logic       pin_b;
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic       rx_prev;
      pdbmc_cnt_t rx_cnt;
      logic       rx_half;
      logic       rx_seen;
      logic       rx_v;
      logic       rx_d;
      logic       idle;
      logic       a_out;
      logic       a_oe_n;
      logic       b_out;
      logic       b_oe_n;
   } pdbmc_phy_s;

   pdbmc_phy_s st_q;
   pdbmc_phy_s st_d;
   pdbmc_sym_s in_sym;
   pdbmc_sym_s head;
   logic       head_v;
   logic       pop;
   logic       rx_lvl;
   logic       rx_edge;

   assign in_sym = '{last: tx_last, data: tx_data};

   pdbmc_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_data   (in_sym),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (head),
      .out_valid (head_v),
      .out_ready (pop)
   );

   // Only the second synchroniser stage feeds the decoder.
   assign rx_lvl  = st_q.pin_b ? st_q.sync_b[1] : st_q.sync_a[1];
   assign rx_edge = (rx_lvl != st_q.rx_prev);

   always_comb begin
      st_d = st_q;
      pop  = 1'b0;
      st_d.rx_v = 1'b0;
      st_d.sync_a = {st_q.sync_a[0], pin_a_in};
      st_d.sync_b = {st_q.sync_b[0], pin_b_in};
      st_d.rx_prev = rx_lvl;

      if (!connect) begin
         st_d.pin_b = orient_b;
      end

      // Stale bits are flushed while nothing is attached.
      if (!connect && st_q.tx_st == TX_IDLE) begin
         pop = head_v;
      end

      unique case (st_q.tx_st)
         TX_IDLE: begin
            if (connect && head_v && st_q.idle) begin
               st_d.tx_st  = TX_LEAD;
               st_d.tx_cnt = CNT_ZERO;
               st_d.line   = 1'b0;
               st_d.drive  = 1'b1;
            end
         end
         TX_LEAD: begin
            st_d.tx_cnt = st_q.tx_cnt + 10'h001;
            if (st_q.tx_cnt == HALF_LAST) begin
               pop          = 1'b1;
               st_d.tx_sym  = head;
               st_d.tx_half = 1'b0;
               st_d.tx_cnt  = CNT_ZERO;
               st_d.line    = ~st_q.line;
               st_d.tx_st   = TX_BITS;
            end
         end
         TX_BITS: begin
            st_d.tx_cnt = st_q.tx_cnt + 10'h001;
            if (st_q.tx_cnt == HALF_LAST) begin
               st_d.tx_cnt = CNT_ZERO;
               if (!st_q.tx_half) begin
                  st_d.tx_half = 1'b1;
                  if (st_q.tx_sym.data) begin
                     st_d.line = ~st_q.line;
                  end
               end else if (st_q.tx_sym.last || !head_v) begin
                  // closing edge after the last bit
                  st_d.line  = ~st_q.line;
                  st_d.tx_st = TX_TAIL;
               end else begin
                  pop          = 1'b1;
                  st_d.tx_sym  = head;
                  st_d.tx_half = 1'b0;
                  st_d.line    = ~st_q.line;
               end
            end
         end
         TX_TAIL: begin
            st_d.tx_cnt = st_q.tx_cnt + 10'h001;
            if (st_q.tx_cnt == HALF_LAST) begin
               st_d.tx_cnt = CNT_ZERO;
               st_d.drive  = 1'b0;
               st_d.tx_st  = TX_IDLE;
            end
         end
      endcase

      // Losing the attach aborts a frame and releases the pin at once.
      if (!connect && st_q.tx_st != TX_IDLE) begin
         st_d.tx_st = TX_IDLE;
         st_d.drive = 1'b0;
      end

      // The own echo is not decoded; squelch restarts once released.
      if (st_q.drive || !connect) begin
         st_d.rx_cnt  = CNT_ZERO;
         st_d.rx_half = 1'b0;
         st_d.rx_seen = 1'b0;
         st_d.idle    = 1'b0;
      end else if (rx_edge) begin
         st_d.rx_cnt = CNT_ZERO;
         st_d.idle   = 1'b0;
         if (!st_q.rx_seen) begin
            st_d.rx_seen = 1'b1;
            st_d.rx_half = 1'b0;
         end else if (st_q.rx_cnt >= THR_CNT) begin
            st_d.rx_v    = 1'b1;
            st_d.rx_d    = 1'b0;
            st_d.rx_half = 1'b0;
         end else if (st_q.rx_half) begin
            // second half interval is a one
            st_d.rx_v    = 1'b1;
            st_d.rx_d    = 1'b1;
            st_d.rx_half = 1'b0;
         end else begin
            st_d.rx_half = 1'b1;
         end
      end else if (st_q.rx_cnt >= IDLE_LAST) begin
         st_d.idle    = 1'b1;
         st_d.rx_seen = 1'b0;
         st_d.rx_half = 1'b0;
      end else begin
         st_d.rx_cnt = st_q.rx_cnt + 10'h001;
      end

      // one pin of this port's pair
      st_d.a_out  = st_d.line;
      st_d.b_out  = st_d.line;
      st_d.a_oe_n = !(st_d.drive && !st_d.pin_b);
      st_d.b_oe_n = !(st_d.drive && st_d.pin_b);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q <= '{tx_st: TX_IDLE, tx_cnt: CNT_ZERO, tx_half: 1'b0,
                   tx_sym: '0, line: LINE_RST, drive: 1'b0, pin_b: 1'b0,
                   sync_a: 2'h0, sync_b: 2'h0, rx_prev: 1'b0,
                   rx_cnt: CNT_ZERO, rx_half: 1'b0, rx_seen: 1'b0,
                   rx_v: 1'b0, rx_d: 1'b0, idle: IDLE_RST,
                   a_out: LINE_RST, a_oe_n: 1'b1, b_out: LINE_RST,
                   b_oe_n: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign rx_valid   = st_q.rx_v;
   assign rx_data    = st_q.rx_d;
   assign rx_idle    = st_q.idle;
   assign tx_busy    = st_q.drive;
   assign pin_a_out  = st_q.a_out;
   assign pin_a_oe_n = st_q.a_oe_n;
   assign pin_b_out  = st_q.b_out;
   assign pin_b_oe_n = st_q.b_oe_n;

endmodule

// [hdl/pdbmc_pkg.sv]
package pdbmc_pkg;

   // Core clock and line timing.
   localparam int CLK_NS     = 40;
   localparam int UI_NS      = 3320;
   localparam int HALF_CYC   = (UI_NS / 2) / CLK_NS;
   localparam int THR_NS     = (UI_NS * 3) / 4;
   localparam int THR_CYC    = (THR_NS + CLK_NS - 1) / CLK_NS;
   localparam int IDLE_NS    = 12000;
   localparam int IDLE_CYC   = (IDLE_NS + CLK_NS - 1) / CLK_NS;

   // Transmit buffer shape.
   localparam int FIFO_W     = 2;
   localparam int FIFO_D     = 8;

   localparam int CNT_W      = 10;
   typedef logic [CNT_W-1:0] pdbmc_cnt_t;

   localparam pdbmc_cnt_t HALF_LAST = pdbmc_cnt_t'(HALF_CYC - 1);
   localparam pdbmc_cnt_t THR_CNT   = pdbmc_cnt_t'(THR_CYC);
   localparam pdbmc_cnt_t IDLE_LAST = pdbmc_cnt_t'(IDLE_CYC - 1);
   localparam pdbmc_cnt_t CNT_ZERO  = 10'h000;

   // Values after reset.
   localparam logic LINE_RST = 1'b0;
   localparam logic IDLE_RST = 1'b1;

   // One symbol bit as handed over by the protocol core.
   typedef struct packed {
      logic last;
      logic data;
   } pdbmc_sym_s;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_LEAD,
      TX_BITS,
      TX_TAIL
   } pdbmc_tx_e;

endpackage

// [dv/pdbmc_phy_properties.sv]
`timescale 1ns/1ps
module pdbmc_phy_properties
   import pdbmc_pkg::*;
(
   input wire logic clk_sys,    // Core clock.
   input wire logic rst_n,      // Reset, low.
   input wire logic connect,    // Attached.
   input wire logic tx_busy,    // Driving.
   input wire logic rx_valid,   // Bit strobe.
   input wire logic rx_idle,    // Bus idle.
   input wire logic pin_a_out,  // Line level.
   input wire logic pin_a_oe_n, // Pin a drive.
   input wire logic pin_b_oe_n  // Pin b drive.
);
   pdbmc_cnt_t cnt_q;
   logic       last_q, busy_q, seen_q, used_a_q, used_b_q, moved;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Spacing is judged only from the first edge after the low lead.
   assign moved = pin_a_out != last_q;
   always_ff @(posedge clk_sys) begin
      last_q   <= pin_a_out;
      busy_q   <= tx_busy;
      seen_q   <= tx_busy && (seen_q || (busy_q && moved));
      cnt_q    <= moved ? CNT_ZERO : cnt_q + 10'h001;
      used_a_q <= connect && (used_a_q || !pin_a_oe_n);
      used_b_q <= connect && (used_b_q || !pin_b_oe_n);
   end

   tx_on_idle_a: assert property (
      $rose(tx_busy) |-> $past(rx_idle) && connect)
      else $error("Sending began on a busy line.");
   lead_low_a: assert property (
      $rose(tx_busy) |-> !pin_a_out [*8] ##[32:34] $rose(pin_a_out))
      else $error("Frame did not open low.");
   edge_space_a: assert property (
      tx_busy && seen_q && moved |-> cnt_q == HALF_LAST
         || cnt_q == pdbmc_cnt_t'(2 * HALF_CYC - 1))
      else $error("Line edge off the half bit grid.");
   drive_busy_a: assert property (
      tx_busy == (!pin_a_oe_n || !pin_b_oe_n))
      else $error("Driver enable differs from busy.");
   one_pin_a: assert property (pin_a_oe_n || pin_b_oe_n)
      else $error("Both pins driven.");
   pin_fixed_a: assert property (
      !(used_a_q && !pin_b_oe_n) && !(used_b_q && !pin_a_oe_n))
      else $error("Pin changed within a connection.");
   rx_strobe_a: assert property (rx_valid |=> !rx_valid [*8])
      else $error("Decoded strobes too close.");
   idle_off_a: assert property (
      !connect ##1 !connect |=> !rx_idle)
      else $error("Idle reported while detached.");
   own_quiet_a: assert property (tx_busy && busy_q |-> !rx_valid)
      else $error("Own frame was decoded.");
endmodule

// [dv/pdbmc_far_end.sv]
`timescale 1ns/1ps
module pdbmc_far_end
   import pdbmc_pkg::*;
(
   input  wire logic clk_sys,  // Core clock.
   output logic      far_out,  // Level on the wire.
   output logic      far_oe_n  // Drive, low drives.
);
   initial begin
      far_out  = 1'b0;
      far_oe_n = 1'b1;
   end

   task automatic send(input logic [11:0] bits, input int n, input bit lose);
      int i;
      @(negedge clk_sys);
      far_out  = 1'b0;
      far_oe_n = 1'b0;
      repeat (HALF_CYC) @(negedge clk_sys);
      for (i = 0; i < n; i++) begin
         if (!(lose && i == 0)) far_out = ~far_out;
         repeat (HALF_CYC) @(negedge clk_sys);
         if (bits[i]) far_out = ~far_out;
         repeat (HALF_CYC) @(negedge clk_sys);
      end
      far_out = ~far_out;
      repeat (HALF_CYC) @(negedge clk_sys);
      far_oe_n = 1'b1;
   endtask
endmodule

// [dv/pdbmc_phy_bench.sv]
`timescale 1ns/1ps
module pdbmc_phy_bench
   import pdbmc_pkg::*;
;
   logic        clk_sys, rst_n, connect, orient_b, tx_valid, tx_data;
   logic        tx_last, tx_ready, rx_valid, rx_data, rx_idle, tx_busy;
   logic        pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, far_out;
   logic        far_oe_n, wire_a, wire_b, ln, last_ln, first, half;
   logic [31:0] seed, r;
   logic        tx_q[$], rx_q[$];
   int          n_mismatch, n_tests, gap, t, i, o, l;
   int          cyc = 0;

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // A released wire falls to its pull-down bias.
   assign wire_a = !pin_a_oe_n ? pin_a_out : !far_oe_n && !orient_b && far_out;
   assign wire_b = !pin_b_oe_n ? pin_b_out : !far_oe_n && orient_b && far_out;

   pdbmc_phy i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .connect(connect),
      .orient_b(orient_b), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_idle(rx_idle), .tx_busy(tx_busy),
      .pin_a_in(wire_a), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
      .pin_b_in(wire_b), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));
   pdbmc_far_end i_far (.clk_sys(clk_sys), .far_out(far_out),
      .far_oe_n(far_oe_n));

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic take(ref logic q[$]);
      return q.size() > 0 ? q.pop_front() : 1'bz;
   endfunction

   task automatic check(input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic push(input logic d, input logic z);
      int k;
      tx_valid = 1'b1;
      tx_data  = d;
      tx_last  = z;
      // Ready is settled here, so the word is taken at the next rising edge.
      for (k = 0; k < 300 && tx_ready !== 1'b1; k++) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask

   // Reference decoder of the driven line, by edge spacing.
   // It looks at the falling edge, where every design output has settled.
   always @(negedge clk_sys) begin
      if (rx_valid) check(rx_data, take(rx_q));
      ln  = orient_b ? wire_b : wire_a;
      gap = gap + 1;
      if (!tx_busy) begin
         first = 1'b1;
         half  = 1'b0;
      end else if (ln !== last_ln) begin
         if (first) first = 1'b0;
         else if (gap >= THR_CYC) check(1'b0, take(tx_q));
         else if (half) begin
            check(1'b1, take(tx_q));
            half = 1'b0;
         end else half = 1'b1;
         gap = 0;
      end
      last_ln = ln;
   end

   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         stop_test();
      end
   end

   initial begin
      n_mismatch = 0;
      n_tests    = 0;
      seed       = 32'h00006E86;
      {rst_n, connect, orient_b, tx_valid, tx_data, tx_last} = 6'h00;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      for (o = 0; o < 2; o++) begin
         connect  = 1'b0;
         orient_b = o[0];
         repeat (4) @(negedge clk_sys);
         check(rx_idle, 1'b0);
         connect = 1'b1;
         for (t = 0; t < 400 && rx_idle !== 1'b1; t++) @(negedge clk_sys);
         check(rx_idle, 1'b1);
         // The second frame has no final mark and ends by running dry.
         for (l = 0; l < 2; l++) begin
            for (t = 0; t < 500 && rx_idle !== 1'b1; t++) @(negedge clk_sys);
            for (i = 0; i < 12 - 9 * l; i++) begin
               r = rnd();
               tx_q.push_back(r[0]);
               push(r[0], i == 11);
               if (i == 7) check(tx_ready, 1'b0);
            end
            tx_valid = 1'b0;
            for (t = 0; t < 3000 && tx_busy !== 1'b0; t++) begin
               @(negedge clk_sys);
            end
            check(tx_q.size() == 0, 1'b1);
            $display("transmit test %0d done on pin %0d", l, o);
         end
         for (l = 0; l < 2; l++) begin
            for (t = 0; t < 500 && rx_idle !== 1'b1; t++) @(negedge clk_sys);
            r = rnd() & 32'h00000FFE;
            for (i = l; i < 12; i++) rx_q.push_back(r[i]);
            i_far.send(r[11:0], 12, l[0]);
            for (t = 0; t < 500 && rx_idle !== 1'b1; t++) @(negedge clk_sys);
            check(rx_q.size() == 0, 1'b1);
            $display("receive test %0d done on pin %0d", l, o);
         end
         // Losing the attach in mid-bit must release the wire at once.
         push(1'b1, 1'b1);
         tx_valid = 1'b0;
         repeat (60) @(negedge clk_sys);
         connect = 1'b0;
         repeat (2) @(negedge clk_sys);
         check(tx_busy, 1'b0);
         check(pin_a_oe_n && pin_b_oe_n, 1'b1);
         $display("detach test done on pin %0d", o);
      end
      stop_test();
   end
endmodule

bind pdbmc_phy pdbmc_phy_properties i_prop (.clk_sys(clk_sys),
   .rst_n(rst_n), .connect(connect), .tx_busy(tx_busy),
   .rx_valid(rx_valid), .rx_idle(rx_idle), .pin_a_out(pin_a_out),
   .pin_a_oe_n(pin_a_oe_n), .pin_b_oe_n(pin_b_oe_n));
